// ### asagg_pkg.sv
// Shared constants and types for the alarm status aggregator.
// Assumes a single system clock and a plain register port from the serial host.
package asagg_pkg;
   localparam int NUM_REF    = 2;   // Reference monitors
   localparam int NUM_LOOP   = 3;   // Two digital phase loops, then the system loop
   localparam int NUM_ALARM  = 3 * NUM_REF + 2 * NUM_LOOP;
   localparam int NUM_BLOCK  = NUM_REF + NUM_LOOP;
   localparam int NUM_PIN    = 4;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 16;

   // Alarm bit positions inside each block
   localparam int REF_FREQ_POS  = 0;
   localparam int REF_LOSS_POS  = 1;
   localparam int REF_ACT_POS   = 2;
   localparam int LOOP_HOLD_POS = 0;
   localparam int LOOP_LOCK_POS = 1;
   localparam int LOOP_BASE     = 3 * NUM_REF;

   // Register offsets
   localparam logic [ADDR_W-1:0] LIVE_OFS       = 8'h00;
   localparam logic [ADDR_W-1:0] STICKY_OFS     = 8'h01;
   localparam logic [ADDR_W-1:0] STICKY_CLR_OFS = 8'h02;
   localparam logic [ADDR_W-1:0] ALERT_EN_OFS   = 8'h03;
   localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h04;
   localparam logic [ADDR_W-1:0] BLK_STICKY_OFS = 8'h05;
   localparam logic [ADDR_W-1:0] BLK_CLR_OFS    = 8'h06;
   localparam logic [ADDR_W-1:0] LOOP_STATE_OFS = 8'h07;
   localparam logic [ADDR_W-1:0] BLK_EN_OFS     = 8'h08;
   localparam logic [ADDR_W-1:0] PIN_CFG_OFS    = 8'h10;

   // Control register fields
   localparam int CTRL_GLOBAL_EN_POS = 0;
   localparam int CTRL_ALERT_INV_POS = 1;
   localparam int CTRL_ALERT_ON_POS  = 2;
   localparam int CTRL_ALERT_PIN_LSB = 4;
   localparam int PIN_IDX_W          = 2;

   // Pin configuration fields
   localparam int PIN_DRIVE_POS  = 0;
   localparam int PIN_INV_POS    = 1;
   localparam int PIN_STICKY_POS = 2;
   localparam int PIN_SRC_LSB    = 4;
   localparam int PIN_SRC_W      = 4;

   // Reset values
   localparam logic [DATA_W-1:0]    CTRL_RST     = 16'h0001;
   localparam logic [NUM_ALARM-1:0] ALERT_EN_RST = 12'h000;
   localparam logic [NUM_BLOCK-1:0] BLK_EN_RST   = 5'h1F;
   localparam logic [7:0]           PIN_CFG_RST  = 8'h00;

   // Loop state machine codes as reported by each phase loop
   typedef enum logic [2:0] {
      ASAGG_FREERUN  = 3'b000,
      ASAGG_LOCKACQ  = 3'b001,
      ASAGG_LOCKREC  = 3'b010,
      ASAGG_LOCKED   = 3'b011,
      ASAGG_HOLDOVER = 3'b100
   } asagg_loop_state_t;

   typedef struct packed {
      logic freq_over;
      logic signal_loss_alarm;
      logic activity;
   } asagg_ref_alarm_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } asagg_bus_req_t;

   typedef struct packed {
      logic [PIN_SRC_W-1:0] src;
      logic                 rsvd;
      logic                 use_sticky;
      logic                 invert;
      logic                 drive;
   } asagg_pin_cfg_t;
endpackage : asagg_pkg

// ### asagg_alarm_aggregator.sv
// Alarm status aggregator: live and sticky alarm status, per-pin alarm
// outputs and one aggregated alert, polled and cleared over a register port.
// Assumes monitor and loop status inputs are already on clock_i.
module asagg_alarm_aggregator
   import asagg_pkg::*;
(
   input  wire logic                          clock_i,      // System clock, 40 MHz
   input  wire logic                          rst_i,        // Async reset, active high
   input  wire asagg_bus_req_t                bus_i,        // Register port request
   output logic [DATA_W-1:0]                  rdata_o,      // Read data, cycle after read
   input  wire asagg_ref_alarm_t [NUM_REF-1:0] ref_alarm_i, // Reference monitor alarms
   input  wire logic [NUM_LOOP-1:0][2:0]      loop_state_i, // Phase loop state codes
   input  wire logic                          analog_phase_loop_locked_i, // Analog loop lock
   output logic [NUM_PIN-1:0]                 pin_o,        // Alarm pin levels
   output logic [NUM_PIN-1:0]                 pin_oe_o      // Alarm pin drive enables
);

   // Block membership mask of the individual alarm bits
   function automatic logic [NUM_ALARM-1:0] block_mask(input int b);
      logic [NUM_ALARM-1:0] m;
      m = '0;
      if (b < NUM_REF) begin
         m[3*b +: 3] = 3'h7;
      end else begin
         m[LOOP_BASE + 2*(b-NUM_REF) +: 2] = 2'h3;
      end
      return m;
   endfunction : block_mask

   // Decode a write strobe for one offset
   function automatic logic wr_hit(input asagg_bus_req_t r, input logic [ADDR_W-1:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction : wr_hit

   // Flat index of one monitor alarm
   function automatic int ref_bit(input int r, input int pos);
      return 3*r + pos;
   endfunction : ref_bit

   // Loss alarms never latch on a non-alert pin, whatever the sticky bit says
   function automatic logic is_loss(input logic [PIN_SRC_W-1:0] idx);
      return (idx < LOOP_BASE) && (idx % 3 == REF_LOSS_POS);
   endfunction : is_loss

   logic [NUM_ALARM-1:0]          live_reg;
   logic [NUM_ALARM-1:0]          live_next;
   logic [NUM_ALARM-1:0]          live_prev_reg;
   logic [NUM_ALARM-1:0]          sticky_reg;
   logic [NUM_ALARM-1:0]          sticky_next;
   logic [NUM_BLOCK-1:0]          blk_sticky_reg;
   logic [NUM_BLOCK-1:0]          blk_sticky_next;
   logic [NUM_ALARM-1:0]          alert_en_reg;
   logic [NUM_BLOCK-1:0]          blk_en_reg;
   logic [DATA_W-1:0]             ctrl_reg;
   asagg_pin_cfg_t [NUM_PIN-1:0]  pin_cfg_reg;
   logic [NUM_LOOP-1:0][2:0]      state_reg;
   logic [DATA_W-1:0]             rdata_reg;
   logic [DATA_W-1:0]             rdata_next;
   logic [NUM_PIN-1:0]            pin_reg;
   logic [NUM_PIN-1:0]            pin_next;
   logic [NUM_PIN-1:0]            pin_oe_reg;
   logic [NUM_PIN-1:0]            pin_oe_next;
   logic [LOOP_BASE-1:0]          ref_live;
   logic [2*NUM_LOOP-1:0]         loop_live;
   logic [NUM_PIN-1:0]            pin_level;
   logic [NUM_PIN-1:0]            wr_pin_cfg;
   logic [NUM_BLOCK-1:0]          blk_hit;
   logic [NUM_BLOCK-1:0]          blk_feeds;
   logic                          alert_raw;
   logic [DATA_W-1:0]             pin_rd;
   logic [DATA_W-1:0]             state_rd;

   wire logic                     global_en = ctrl_reg[CTRL_GLOBAL_EN_POS];
   wire logic                     alert_inv = ctrl_reg[CTRL_ALERT_INV_POS];
   wire logic                     alert_on  = ctrl_reg[CTRL_ALERT_ON_POS];
   wire logic [PIN_IDX_W-1:0]     alert_pin = ctrl_reg[CTRL_ALERT_PIN_LSB +: PIN_IDX_W];
   wire logic [NUM_ALARM-1:0]     change    = live_reg ^ live_prev_reg;
   wire logic [NUM_ALARM-1:0]     set_mask  = change & {NUM_ALARM{global_en}};
   wire logic                     wr_s_clr  = wr_hit(bus_i, STICKY_CLR_OFS);
   wire logic                     wr_b_clr  = wr_hit(bus_i, BLK_CLR_OFS);
   wire logic                     wr_al_en  = wr_hit(bus_i, ALERT_EN_OFS);
   wire logic                     wr_b_en   = wr_hit(bus_i, BLK_EN_OFS);
   wire logic                     wr_ctrl   = wr_hit(bus_i, CTRL_OFS);
   wire logic [NUM_ALARM-1:0]     clr_mask  = wr_s_clr ? bus_i.wdata[NUM_ALARM-1:0] : '0;
   wire logic [NUM_BLOCK-1:0]     blk_clr   = wr_b_clr ? bus_i.wdata[NUM_BLOCK-1:0] : '0;

   // Monitor alarms pass straight through
   always_comb begin
      for (int r = 0; r < NUM_REF; r++) begin
         ref_live[ref_bit(r, REF_FREQ_POS)] = ref_alarm_i[r].freq_over;
         ref_live[ref_bit(r, REF_LOSS_POS)] = ref_alarm_i[r].signal_loss_alarm;
         ref_live[ref_bit(r, REF_ACT_POS)]  = ref_alarm_i[r].activity;
      end
   end

   // Loop alarms come from the registered state code
   always_comb begin
      for (int l = 0; l < NUM_LOOP; l++) begin
         loop_live[2*l + LOOP_HOLD_POS] = (state_reg[l] == ASAGG_HOLDOVER);
         loop_live[2*l + LOOP_LOCK_POS] = (state_reg[l] == ASAGG_LOCKED) && analog_phase_loop_locked_i;
      end
   end

   assign live_next = {loop_live, ref_live};

   // Sticky bits: a change event sets, a clear write drops; the set wins
   // so an edge landing beside a clear is never lost
   always_comb begin
      for (int i = 0; i < NUM_ALARM; i++) begin
         if (set_mask[i]) begin
            sticky_next[i] = 1'b1;
         end else if (clr_mask[i]) begin
            sticky_next[i] = 1'b0;
         end else begin
            sticky_next[i] = sticky_reg[i];
         end
      end
   end

   // Per block: an individual sticky pending, and a route onto the alert
   always_comb begin
      for (int b = 0; b < NUM_BLOCK; b++) begin
         blk_hit[b]   = blk_en_reg[b] && global_en && |(sticky_next & block_mask(b));
         blk_feeds[b] = blk_sticky_reg[b] && |(alert_en_reg & block_mask(b));
      end
   end

   // Block sticky re-asserts while any of its individual stickies stays set
   always_comb begin
      for (int b = 0; b < NUM_BLOCK; b++) begin
         if (blk_hit[b]) begin
            blk_sticky_next[b] = 1'b1;
         end else if (blk_clr[b]) begin
            blk_sticky_next[b] = 1'b0;
         end else begin
            blk_sticky_next[b] = blk_sticky_reg[b];
         end
      end
   end

   // Alert: OR of enabled stickies plus block stickies feeding an enabled alarm
   always_comb begin
      alert_raw = |(sticky_reg & alert_en_reg);
      if (|blk_feeds) begin
         alert_raw = 1'b1;
      end
   end

   // Level each pin shows before inversion; out-of-range sources show low
   always_comb begin
      for (int p = 0; p < NUM_PIN; p++) begin
         if (pin_cfg_reg[p].src >= NUM_ALARM) begin
            pin_level[p] = 1'b0;
         end else if (pin_cfg_reg[p].use_sticky && !is_loss(pin_cfg_reg[p].src)) begin
            pin_level[p] = sticky_reg[pin_cfg_reg[p].src];
         end else begin
            pin_level[p] = live_reg[pin_cfg_reg[p].src];
         end
      end
   end

   // Pin drive; the alert negates one cycle after its last source clears
   always_comb begin
      for (int p = 0; p < NUM_PIN; p++) begin
         if (alert_on && (alert_pin == p[PIN_IDX_W-1:0])) begin
            pin_oe_next[p] = 1'b1;
            pin_next[p]    = alert_raw ^ alert_inv;
         end else begin
            pin_oe_next[p] = pin_cfg_reg[p].drive;
            pin_next[p]    = pin_level[p] ^ pin_cfg_reg[p].invert;
         end
      end
   end

   // Pin configuration read word
   always_comb begin
      pin_rd = '0;
      for (int p = 0; p < NUM_PIN; p++) begin
         if (bus_i.addr == PIN_CFG_OFS + p[ADDR_W-1:0]) begin
            pin_rd = {8'h00, pin_cfg_reg[p]};
         end
      end
   end

   // Loop state read word, three bits per loop
   always_comb begin
      state_rd = '0;
      state_rd[3*NUM_LOOP-1:0] = state_reg;
   end

   // One write strobe per pin configuration word
   always_comb begin
      for (int p = 0; p < NUM_PIN; p++) begin
         wr_pin_cfg[p] = wr_hit(bus_i, PIN_CFG_OFS + p[ADDR_W-1:0]);
      end
   end

   // Read decode; idle cycles return zero so the data stand one cycle only
   always_comb begin
      if (!bus_i.rd) begin
         rdata_next = '0;
      end else if (bus_i.addr == LIVE_OFS) begin
         rdata_next = DATA_W'(live_reg);
      end else if (bus_i.addr == STICKY_OFS) begin
         rdata_next = DATA_W'(sticky_reg);
      end else if (bus_i.addr == ALERT_EN_OFS) begin
         rdata_next = DATA_W'(alert_en_reg);
      end else if (bus_i.addr == CTRL_OFS) begin
         rdata_next = ctrl_reg;
      end else if (bus_i.addr == BLK_STICKY_OFS) begin
         rdata_next = DATA_W'(blk_sticky_reg);
      end else if (bus_i.addr == LOOP_STATE_OFS) begin
         rdata_next = state_rd;
      end else if (bus_i.addr == BLK_EN_OFS) begin
         rdata_next = DATA_W'(blk_en_reg);
      end else begin
         rdata_next = pin_rd;
      end
   end

   // Loop state register; live bits lag it by one cycle
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= loop_state_i;
      end
   end

   // Live bits
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         live_reg <= '0;
      end else begin
         live_reg <= live_next;
      end
   end

   // Previous live bits; both reset low, so no false change after reset
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         live_prev_reg <= '0;
      end else begin
         live_prev_reg <= live_reg;
      end
   end

   // Individual sticky bits
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sticky_reg <= '0;
      end else begin
         sticky_reg <= sticky_next;
      end
   end

   // Block sticky bits
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         blk_sticky_reg <= '0;
      end else begin
         blk_sticky_reg <= blk_sticky_next;
      end
   end

   // Alert enables
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         alert_en_reg <= ALERT_EN_RST;
      end else if (wr_al_en) begin
         alert_en_reg <= bus_i.wdata[NUM_ALARM-1:0];
      end
   end

   // Block enables
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         blk_en_reg <= BLK_EN_RST;
      end else if (wr_b_en) begin
         blk_en_reg <= bus_i.wdata[NUM_BLOCK-1:0];
      end
   end

   // Control word; reserved bits stay zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_reg <= bus_i.wdata & 16'h0037;
      end
   end

   // Pin configuration words
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_cfg_reg <= {NUM_PIN{PIN_CFG_RST}};
      end else begin
         for (int p = 0; p < NUM_PIN; p++) begin
            if (wr_pin_cfg[p]) begin
               pin_cfg_reg[p] <= bus_i.wdata[7:0] & 8'hF7;
            end
         end
      end
   end

   // Read data flop
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Pin level flops keep the pins free of decode glitches
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_reg <= '0;
      end else begin
         pin_reg <= pin_next;
      end
   end

   // Pin drive enable flops
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_oe_reg <= '0;
      end else begin
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign rdata_o  = rdata_reg;
   assign pin_o    = pin_reg;
   assign pin_oe_o = pin_oe_reg;

endmodule : asagg_alarm_aggregator

// ### asagg_monitor.sv
// Port checker for the alarm status aggregator, bound to its top module.
// Assumes status inputs stay quiet while control registers are rewritten.
module asagg_monitor
   import asagg_pkg::*;
(
   input wire logic                           clock_i,      // System clock
   input wire logic                           rst_i,        // Async reset
   input wire asagg_bus_req_t                 bus_i,        // Register request
   input wire logic [DATA_W-1:0]              rdata_o,      // Read data
   input wire asagg_ref_alarm_t [NUM_REF-1:0] ref_alarm_i,  // Monitor alarms
   input wire logic [NUM_LOOP-1:0][2:0]       loop_state_i, // Loop states
   input wire logic                           analog_phase_loop_locked_i, // Analog lock
   input wire logic [NUM_PIN-1:0]             pin_o,        // Pin levels
   input wire logic [NUM_PIN-1:0]             pin_oe_o      // Pin enables
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic [DATA_W-1:0]       ctrl_reg;
   logic [NUM_ALARM-1:0]    alen_reg;
   logic [NUM_PIN-1:0][7:0] cfg_reg;
   logic [5:0]              pend_reg;
   logic [5:0]              prev_reg;
   logic [5:0]              chg_reg;
   logic [NUM_ALARM-1:0]    live_exp;
   wire  [5:0]              clr = (bus_i.wr && bus_i.addr == STICKY_CLR_OFS) ? bus_i.wdata[5:0] : 6'h00;
   wire                     rd_live = bus_i.rd && bus_i.addr == LIVE_OFS;
   wire  [PIN_IDX_W-1:0]    apin = ctrl_reg[CTRL_ALERT_PIN_LSB +: PIN_IDX_W];
   always_comb begin
      for (int r = 0; r < NUM_REF; r++)
         live_exp[3*r +: 3] = {ref_alarm_i[r].activity, ref_alarm_i[r].signal_loss_alarm, ref_alarm_i[r].freq_over};
      for (int l = 0; l < NUM_LOOP; l++)
         live_exp[LOOP_BASE+2*l +: 2] = {loop_state_i[l] == ASAGG_LOCKED && analog_phase_loop_locked_i,
                                          loop_state_i[l] == ASAGG_HOLDOVER};
   end
   // Sticky shadow sets two edges after an input change; set beats a clear
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
         alen_reg <= ALERT_EN_RST;
         cfg_reg  <= '0;
         pend_reg <= '0;
         prev_reg <= '0;
         chg_reg  <= '0;
      end else begin
         if (bus_i.wr && bus_i.addr == CTRL_OFS) ctrl_reg <= bus_i.wdata;
         if (bus_i.wr && bus_i.addr == ALERT_EN_OFS) alen_reg <= bus_i.wdata[NUM_ALARM-1:0];
         if (bus_i.wr && bus_i.addr[7:2] == 6'h04) cfg_reg[bus_i.addr[1:0]] <= bus_i.wdata[7:0];
         prev_reg <= live_exp[5:0];
         chg_reg  <= live_exp[5:0] ^ prev_reg;
         pend_reg <= (pend_reg & ~clr) | (chg_reg & {6{ctrl_reg[CTRL_GLOBAL_EN_POS]}});
      end
   end
   sequence quiet_s;
      $stable({ref_alarm_i, loop_state_i, analog_phase_loop_locked_i, ctrl_reg, alen_reg, cfg_reg, pend_reg}) [*4];
   endsequence
   a_live_ref: assert property (quiet_s ##0 rd_live |=> rdata_o[5:0] == $past(live_exp[5:0]))
      else $error("live monitor bits wrong");
   a_live_hold: assert property (quiet_s ##0 rd_live |=> (rdata_o[11:0] & 12'h540) == ($past(live_exp) & 12'h540))
      else $error("holdover live bits wrong");
   a_live_lock: assert property (quiet_s ##0 rd_live |=> (rdata_o[11:0] & 12'hA80) == ($past(live_exp) & 12'hA80))
      else $error("locked live bits wrong");
   a_state_read: assert property (quiet_s ##0 bus_i.rd && bus_i.addr == LOOP_STATE_OFS |=>
      rdata_o[8:0] == $past(loop_state_i)) else $error("loop state read wrong");
   a_sticky_track: assert property (bus_i.rd && bus_i.addr == STICKY_OFS |=>
      rdata_o[5:0] == $past(pend_reg)) else $error("sticky monitor bits wrong");
   a_loss_pin: assert property (quiet_s ##0 cfg_reg[0][PIN_DRIVE_POS] && cfg_reg[0][7:4] == 4'h1 &&
      !(ctrl_reg[CTRL_ALERT_ON_POS] && apin == 2'h0) |-> pin_oe_o[0] &&
      pin_o[0] == (ref_alarm_i[0].signal_loss_alarm ^ cfg_reg[0][PIN_INV_POS])) else $error("loss pin wrong");
   a_alert_set: assert property (quiet_s ##0 ctrl_reg[CTRL_ALERT_ON_POS] && |(pend_reg & alen_reg[5:0]) |->
      pin_o[apin] == !ctrl_reg[CTRL_ALERT_INV_POS]) else $error("alert not asserted");
   a_alert_drive: assert property (quiet_s ##0 ctrl_reg[CTRL_ALERT_ON_POS] |-> pin_oe_o[apin])
      else $error("alert pin not driven");
   cover property (rd_live ##1 rdata_o != 16'h0000);
   cover property (ctrl_reg[CTRL_ALERT_ON_POS] && pin_o[apin] != ctrl_reg[CTRL_ALERT_INV_POS]);
   cover property (cfg_reg[0][PIN_DRIVE_POS] && pin_o[0]);
endmodule : asagg_monitor

bind asagg_alarm_aggregator asagg_monitor asagg_monitor_i (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .ref_alarm_i(ref_alarm_i), .loop_state_i(loop_state_i),
   .analog_phase_loop_locked_i(analog_phase_loop_locked_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

// ### asagg_host_model.sv
// Host processor model: polls and clears alarm status over the register port.
// Assumes read data stand only in the cycle after the read strobe.
module asagg_host_model
   import asagg_pkg::*;
(
   input  wire logic              clock_i, // System clock
   input  wire logic [DATA_W-1:0] rdata_i, // Read data
   output asagg_bus_req_t         bus_o    // Register request
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bus_o = '0;
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock_i);
      bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      bus_o <= '0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clock_i);
      bus_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      bus_o <= '0;
      #1 d = rdata_i;
   endtask : rd
   // Individual bits first, or the block bit would set again
   task automatic clear_all();
      wr(STICKY_CLR_OFS, 16'hFFFF);
      wr(BLK_CLR_OFS, 16'hFFFF);
   endtask : clear_all
endmodule : asagg_host_model

// ### tb_asagg_alarm_aggregator.sv
// Self-checking bench for the alarm status aggregator.
// Assumes the host model owns the register port; the bench drives status inputs.
module tb_asagg_alarm_aggregator;
   import asagg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic                           clock_i;
   logic                           rst_i = 1'b1;
   logic                           analog_reg = 1'b0;
   asagg_bus_req_t                 bus;
   asagg_ref_alarm_t [NUM_REF-1:0] ref_reg = '0;
   logic [NUM_LOOP-1:0][2:0]       loop_reg = '0;
   logic [DATA_W-1:0]              rdata;
   logic [NUM_PIN-1:0]             pin;
   logic [NUM_PIN-1:0]             pin_oe;
   logic [31:0]                    seed = 32'd30726;
   int                             fail_count = 0;
   int                             n_compared = 0;
   int                             k;
   logic [DATA_W-1:0]              rdata_probe;
   asagg_alarm_aggregator asagg_alarm_aggregator_i (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
      .ref_alarm_i(ref_reg), .loop_state_i(loop_reg), .analog_phase_loop_locked_i(analog_reg), .pin_o(pin),
      .pin_oe_o(pin_oe));
   asagg_host_model asagg_host_model_i (.clock_i(clock_i), .rdata_i(rdata), .bus_o(bus));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [DATA_W-1:0] live_of(input logic [5:0] r, input logic [8:0] l, input logic a);
      live_of = {10'h000, r[3], r[4], r[5], r[0], r[1], r[2]};
      for (int i = 0; i < NUM_LOOP; i++)
         live_of[LOOP_BASE+2*i +: 2] = {l[3*i +: 3] == 3'h3 && a, l[3*i +: 3] == 3'h4};
   endfunction : live_of
   task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string what);
      logic [DATA_W-1:0] v;
      asagg_host_model_i.rd(a, v);
      check(what, v, e);
   endtask : rdchk
   task automatic settle(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : settle
   task automatic put(input logic [5:0] r, input logic [8:0] l, input logic a);
      @(posedge clock_i);
      ref_reg <= r;
      loop_reg <= l;
      analog_reg <= a;
      settle(4);
   endtask : put
   task automatic test_done();
      if (fail_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   initial begin
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      rdchk(CTRL_OFS, CTRL_RST, "ctrl");
      rdchk(BLK_EN_OFS, 16'h001F, "blk_en");
      rdchk(8'h20, 16'h0000, "unmapped");
      put(6'h02, 9'h000, 1'b0);
      rdchk(STICKY_OFS, 16'h0002, "sticky_set");
      put(6'h00, 9'h000, 1'b0);
      rdchk(STICKY_OFS, 16'h0002, "sticky_hold");
      put(6'h28, 9'h000, 1'b0);
      asagg_host_model_i.wr(STICKY_CLR_OFS, 16'h000A);
      rdchk(STICKY_OFS, 16'h0020, "sticky_subset");
      asagg_host_model_i.clear_all();
      asagg_host_model_i.wr(CTRL_OFS, 16'h0000);
      put(6'h01, 9'h000, 1'b0);
      rdchk(STICKY_OFS, 16'h0000, "sticky_masked");
      rdchk(LIVE_OFS, 16'h0004, "live_masked");
      asagg_host_model_i.wr(CTRL_OFS, 16'h0001);
      put(6'h01, 9'h018, 1'b1);
      rdchk(STICKY_OFS, 16'h0200, "loop_sticky");
      rdchk(BLK_STICKY_OFS, 16'h0008, "loop_block");
      rdchk(LOOP_STATE_OFS, 16'h0018, "loop_state");
      put(6'h01, 9'h018, 1'b0);
      rdchk(LIVE_OFS, 16'h0004, "lock_analog");
      // Alert on pin 2, inverted, enabled on ref0 loss, so any ref0 alarm feeds it through block 0
      asagg_host_model_i.clear_all();
      asagg_host_model_i.wr(ALERT_EN_OFS, 16'h0002);
      asagg_host_model_i.wr(CTRL_OFS, 16'h0027);
      put(6'h21, 9'h018, 1'b0);
      check("alert_idle", {15'h0000, pin[2]}, 16'h0001);
      put(6'h23, 9'h018, 1'b0);
      check("alert_set", {15'h0000, pin[2]}, 16'h0000);
      put(6'h21, 9'h018, 1'b0);
      check("alert_kept", {15'h0000, pin[2]}, 16'h0000);
      asagg_host_model_i.clear_all();
      for (k = 0; k < 8000 && pin[2] !== 1'b1; k++) settle(1);
      check("alert_clear", {15'h0000, pin[2]}, 16'h0001);
      if (pin[2] !== 1'b1) test_done();
      asagg_host_model_i.wr(PIN_CFG_OFS, 16'h0017);
      asagg_host_model_i.wr(PIN_CFG_OFS + 8'h01, 16'h0065);
      put(6'h02, 9'h004, 1'b0);
      check("loss_pin", {15'h0000, pin[0]}, 16'h0000);
      check("hold_pin", {15'h0000, pin[1]}, 16'h0001);
      rdchk(LIVE_OFS, 16'h0042, "live_hold");
      put(6'h00, 9'h000, 1'b0);
      check("loss_pin_off", {15'h0000, pin[0]}, 16'h0001);
      check("hold_pin_kept", {15'h0000, pin[1]}, 16'h0001);
      for (int i = 0; i < 300; i++) begin
         seed = xs(seed);
         @(posedge clock_i);
         ref_reg <= seed[5:0];
         loop_reg <= {seed[8:6] % 3'd5, seed[11:9] % 3'd5, seed[14:12] % 3'd5};
         analog_reg <= seed[15];
         if (seed[16]) asagg_host_model_i.wr(STICKY_CLR_OFS, seed[31:16]);
         settle(4);
         rdchk(LIVE_OFS, live_of(ref_reg, loop_reg, analog_reg), "live");
         asagg_host_model_i.rd(STICKY_OFS, rdata_probe);
      end
      test_done();
   end
endmodule : tb_asagg_alarm_aggregator
